//--- rtl/utcr_defines.svh
// Constants for the power-hold timer and configuration register bank.
// Assumes a 40 MHz core clock and a byte-wide register port from an I2C slave front end.
// Notes on behaviour
// - On battery after cable loss, count sixty seconds plus one minute per unit.
// - On run-time expiry, request safe shutdown without restart, cut battery, sleep.
// - Run-time value 0xff disables the timer; battery runs to its discharge limit.
// - Cable power returning during run-time sleep restarts the host automatically.
// - Key held over two seconds in sleep restarts host; full run time reapplies.
// - Run-time register resets to zero, meaning sixty seconds; highest count 0xFE.
// - Run-time register reads its value any time; any byte write accepted.
// - Each run-time register write requests an immediate nonvolatile store.
// - Serial rate register configures the serial port; 0x00 is off and default.
// - Rate codes 01..05 and 0F select 4800 to 115200 bits per second.
// - A keep-alive countdown register counts in seconds.
// - Keep-alive value 0xff disables the countdown and is the default.
// - Values 01..fe count down per second; zero forces host hardware reset.
// - Writing 0x00 to keep-alive starts safe shutdown followed by restart.
// - After a keep-alive restart completes, the register returns to 0xff.
`ifndef UTCR_DEFINES_SVH
`define UTCR_DEFINES_SVH
`define UTCR_OFS_HOLD 8'h01
`define UTCR_OFS_BAUD 8'h02
`define UTCR_OFS_KEEP 8'h05
`define UTCR_RST_HOLD 8'h00
`define UTCR_RST_BAUD 8'h00
`define UTCR_RST_KEEP 8'hff
`define UTCR_OFF_CODE 8'hff
`define UTCR_CLK_HZ 40000000
`define UTCR_SEC_CYC (`UTCR_CLK_HZ)
`define UTCR_MIN_SEC 60
`define UTCR_KEY_SEC 2
`endif

//--- rtl/utcr_pkg.sv
// Types for the power-hold timer and configuration register bank.
// Assumes nothing beyond the defines header.
`default_nettype none
package utcr_pkg;
  typedef enum logic [1:0] {
    UTCR_RUN = 2'b00,
    UTCR_HOLD = 2'b01,
    UTCR_SLEEP = 2'b10
  } utcr_state_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } utcr_req_t;
  typedef enum logic [3:0] {
    UTCR_B_OFF = 4'h0,
    UTCR_B_4800 = 4'h1,
    UTCR_B_9600 = 4'h2,
    UTCR_B_19200 = 4'h3,
    UTCR_B_34600 = 4'h4,
    UTCR_B_57600 = 4'h5,
    UTCR_B_115200 = 4'hf
  } utcr_baud_t;
endpackage : utcr_pkg
`default_nettype wire

//--- rtl/utcr_regs.sv
// Register bank for battery hold time, serial rate select and keep-alive countdown.
// Assumes req comes from an I2C slave front end on core_clk; power and key inputs are pins.
`include "utcr_defines.svh"
`default_nettype none
module utcr_regs (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Register port
  input wire utcr_pkg::utcr_req_t req,
  output logic [7:0] rdata,
  // Pins
  input wire logic cable_ok,
  input wire logic user_key,
  input wire logic restart_done,
  // Power control
  output logic nv_store,
  output logic shutdown_req,
  output logic restart_req,
  output logic host_reset,
  output logic batt_disconnect,
  output logic low_power_sleep,
  // Serial port
  output logic serial_on,
  output utcr_pkg::utcr_baud_t serial_rate
);
  localparam logic [25:0] SEC_LAST = 26'(`UTCR_SEC_CYC - 1);
  localparam logic [5:0] MIN_LAST = 6'(`UTCR_MIN_SEC - 1);
  localparam logic [1:0] KEY_LAST = 2'(`UTCR_KEY_SEC);

  logic cab_s1_q, cab_s2_q, key_s1_q, key_s2_q, done_s1_q, done_s2_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cab_s1_q <= 1'b0;
      cab_s2_q <= 1'b0;
      key_s1_q <= 1'b0;
      key_s2_q <= 1'b0;
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
    end else begin
      cab_s1_q <= cable_ok;
      cab_s2_q <= cab_s1_q;
      key_s1_q <= user_key;
      key_s2_q <= key_s1_q;
      done_s1_q <= restart_done;
      done_s2_q <= done_s1_q;
    end
  end

  logic [25:0] div_q, div_d;
  logic [5:0] sec_q, sec_d;
  logic [7:0] hold_q, hold_d, baud_q, baud_d, keep_q, keep_d, rdata_d;
  logic [7:0] mins_q, mins_d;
  logic [1:0] keysec_q, keysec_d;
  logic keep_wait_q, keep_wait_d;
  utcr_pkg::utcr_state_t st_q, st_d;
  logic nv_d, shut_d, rst_d, host_d, disc_d, sleep_d, son_d;
  utcr_pkg::utcr_baud_t rate_d;
  logic sec_tick, min_tick, wr_keep, wr_hold;

  always_comb begin
    sec_tick = (div_q == SEC_LAST);
    min_tick = sec_tick && (sec_q == MIN_LAST);
    div_d = sec_tick ? 26'h0000000 : div_q + 26'h0000001;
    sec_d = sec_q;
    // The minute prescaler restarts whenever the hold timer is idle; the second divider runs free, so the first minute may be up to a second short.
    if (st_q != utcr_pkg::UTCR_HOLD) begin
      sec_d = 6'h00;
    end else if (sec_tick) begin
      sec_d = (sec_q == MIN_LAST) ? 6'h00 : sec_q + 6'h01;
    end
    wr_hold = req.wr && (req.addr == `UTCR_OFS_HOLD);
    wr_keep = req.wr && (req.addr == `UTCR_OFS_KEEP);
    hold_d = wr_hold ? req.wdata : hold_q;
    nv_d = wr_hold;
    baud_d = (req.wr && req.addr == `UTCR_OFS_BAUD) ? req.wdata : baud_q;
    son_d = (baud_d == 8'h01) || (baud_d == 8'h02) || (baud_d == 8'h03) ||
            (baud_d == 8'h04) || (baud_d == 8'h05) || (baud_d == 8'h0f);
    rate_d = son_d ? utcr_pkg::utcr_baud_t'(baud_d[3:0]) : utcr_pkg::UTCR_B_OFF;
    keep_d = keep_q;
    keep_wait_d = keep_wait_q;
    host_d = 1'b0;
    rst_d = 1'b0;
    if (keep_wait_q && done_s2_q) begin
      keep_d = `UTCR_OFF_CODE;
      keep_wait_d = 1'b0;
    end
    if (wr_keep) begin
      keep_d = req.wdata;
      if (req.wdata == 8'h00) begin
        rst_d = 1'b1;
        keep_wait_d = 1'b1;
      end
    end else if (sec_tick && keep_q != `UTCR_OFF_CODE && keep_q != 8'h00) begin
      keep_d = keep_q - 8'h01;
      if (keep_q == 8'h01) begin
        host_d = 1'b1;
        keep_wait_d = 1'b1;
      end
    end
    case (req.addr)
      `UTCR_OFS_HOLD: rdata_d = hold_q;
      `UTCR_OFS_BAUD: rdata_d = baud_q;
      `UTCR_OFS_KEEP: rdata_d = keep_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always_comb begin
    st_d = st_q;
    mins_d = mins_q;
    keysec_d = keysec_q;
    shut_d = 1'b0;
    disc_d = 1'b0;
    sleep_d = 1'b0;
    case (st_q)
      utcr_pkg::UTCR_RUN: begin
        mins_d = 8'h00;
        if (!cab_s2_q && hold_q != `UTCR_OFF_CODE) begin
          st_d = utcr_pkg::UTCR_HOLD;
        end
      end
      utcr_pkg::UTCR_HOLD: begin
        if (cab_s2_q || hold_q == `UTCR_OFF_CODE) begin
          st_d = utcr_pkg::UTCR_RUN;
        end else if (min_tick) begin
          // Count zero expires after the sixty-second base alone.
          if (mins_q >= hold_q) begin
            shut_d = 1'b1;
            st_d = utcr_pkg::UTCR_SLEEP;
          end else begin
            mins_d = mins_q + 8'h01;
          end
        end
      end
      utcr_pkg::UTCR_SLEEP: begin
        disc_d = 1'b1;
        sleep_d = 1'b1;
        if (!key_s2_q) begin
          keysec_d = 2'h0;
        end else if (sec_tick && keysec_q != 2'h3) begin
          keysec_d = keysec_q + 2'h1;
        end
        // Three ticks while held means at least two full seconds, since the first tick may come
        // at once; the price is up to one extra second of holding.
        if (cab_s2_q || (keysec_q > KEY_LAST && key_s2_q)) begin
          st_d = utcr_pkg::UTCR_RUN;
          disc_d = 1'b0;
          sleep_d = 1'b0;
          keysec_d = 2'h0;
        end
      end
      default: st_d = utcr_pkg::UTCR_RUN;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= 26'h0000000;
      sec_q <= 6'h00;
      hold_q <= `UTCR_RST_HOLD;
      baud_q <= `UTCR_RST_BAUD;
      keep_q <= `UTCR_RST_KEEP;
      mins_q <= 8'h00;
      keysec_q <= 2'h0;
      keep_wait_q <= 1'b0;
      st_q <= utcr_pkg::UTCR_RUN;
      rdata <= 8'h00;
      nv_store <= 1'b0;
      shutdown_req <= 1'b0;
      restart_req <= 1'b0;
      host_reset <= 1'b0;
      batt_disconnect <= 1'b0;
      low_power_sleep <= 1'b0;
      serial_on <= 1'b0;
      serial_rate <= utcr_pkg::UTCR_B_OFF;
    end else begin
      div_q <= div_d;
      sec_q <= sec_d;
      hold_q <= hold_d;
      baud_q <= baud_d;
      keep_q <= keep_d;
      mins_q <= mins_d;
      keysec_q <= keysec_d;
      keep_wait_q <= keep_wait_d;
      st_q <= st_d;
      rdata <= rdata_d;
      nv_store <= nv_d;
      shutdown_req <= shut_d;
      restart_req <= rst_d;
      host_reset <= host_d;
      batt_disconnect <= disc_d;
      low_power_sleep <= sleep_d;
      serial_on <= son_d;
      serial_rate <= rate_d;
    end
  end

  nv_store_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (req.wr && req.addr == `UTCR_OFS_HOLD) |=> nv_store && hold_q == $past(req.wdata))
    else $error("run-time write not stored");
  keep_zero_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (req.wr && req.addr == `UTCR_OFS_KEEP && req.wdata == 8'h00) |=> restart_req)
    else $error("keep-alive zero did not restart");
  keep_off_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (keep_q == 8'hff && !req.wr) |=> keep_q == 8'hff)
    else $error("disabled keep-alive changed");
  keep_tick_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (sec_tick && !req.wr && keep_q == 8'h01) |=> host_reset && keep_q == 8'h00)
    else $error("keep-alive expiry missed");
  keep_back_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (keep_wait_q && done_s2_q && !req.wr) |=> keep_q == 8'hff)
    else $error("keep-alive not restored");
  hold_off_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (hold_q == 8'hff && st_q == utcr_pkg::UTCR_HOLD) |=> st_q == utcr_pkg::UTCR_RUN)
    else $error("disabled run timer kept running");
  sleep_out_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (shutdown_req && !cab_s2_q) |-> ##1 (low_power_sleep && batt_disconnect))
    else $error("no sleep after shutdown");
  cable_wake_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (st_q == utcr_pkg::UTCR_SLEEP && cab_s2_q) |=> st_q == utcr_pkg::UTCR_RUN)
    else $error("cable return did not wake");
  baud_map_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (req.wr && req.addr == `UTCR_OFS_BAUD && req.wdata == 8'h0f) |=>
    serial_on && serial_rate == utcr_pkg::UTCR_B_115200)
    else $error("115200 code not applied");
  sec_exact_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    sec_tick |=> div_q == 26'h0000000)
    else $error("second divider wrong");
endmodule : utcr_regs
`default_nettype wire

//--- tb/utcr_host.sv
// Host-side model that answers restart requests with a completion level.
// Assumes restart pulses from the register bank on core_clk.
`default_nettype none
module utcr_host (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Restart handshake
  input wire logic restart_req,
  input wire logic slow,
  output logic restart_done
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt_q;
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= -6;
    end else if (restart_req) begin
      cnt_q <= slow ? 40 : 4;
    end else if (cnt_q > -6) begin
      cnt_q <= cnt_q - 1;
    end
  end
  // Done stands six edges so that the two-flop pin synchroniser cannot miss it.
  assign restart_done = (cnt_q <= 0) && (cnt_q > -6);
endmodule : utcr_host
`default_nettype wire

//--- tb/utcr_regs_test.sv
// Self-checking bench for the register bank, with the host restart model.
// Assumes the one-second divider is never reached, so the keep-alive count is only started and the hold timer, set to 0xff, never starts.
`default_nettype none
module utcr_regs_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 0, rst_b = 0, cable_ok = 1, user_key = 0, slow = 0, look = 0;
  utcr_pkg::utcr_req_t req = '0;
  logic [7:0] rdata;
  logic nv_store, shutdown_req, restart_req, host_reset, batt_disconnect;
  logic low_power_sleep, serial_on, restart_done;
  utcr_pkg::utcr_baud_t serial_rate;
  logic [7:0] expq[$];
  int miscompares = 0, checks = 0, cyc = 0, n_nv = 0, n_rr = 0, n_bad = 0;
  utcr_regs i_dut (.core_clk(core_clk), .rst_b(rst_b), .req(req), .rdata(rdata),
    .cable_ok(cable_ok), .user_key(user_key), .restart_done(restart_done),
    .nv_store(nv_store), .shutdown_req(shutdown_req), .restart_req(restart_req),
    .host_reset(host_reset), .batt_disconnect(batt_disconnect),
    .low_power_sleep(low_power_sleep), .serial_on(serial_on), .serial_rate(serial_rate));
  utcr_host i_host (.core_clk(core_clk), .rst_b(rst_b), .restart_req(restart_req),
    .slow(slow), .restart_done(restart_done));
  always #12.5 core_clk = ~core_clk;
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge core_clk);
    req.wr = 1'b0;
    @(negedge core_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    req.addr = a;
    expq.push_back(e);
    repeat (2) @(negedge core_clk);
    look = 1'b1;
    @(negedge core_clk);
    look = 1'b0;
  endtask : rd
  // The watcher pairs each settled read with the oldest noted expectation.
  always @(posedge look) begin
    chk("rdata", expq.pop_front(), rdata);
  end
  always @(posedge core_clk) begin
    cyc++;
    n_nv += int'(nv_store === 1'b1);
    n_rr += int'(restart_req === 1'b1);
    n_bad += int'(shutdown_req !== 1'b0 || host_reset !== 1'b0 || low_power_sleep !== 1'b0
      || batt_disconnect !== 1'b0);
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    logic [7:0] v;
    logic [7:0] e;
    logic [7:0] codes[9];
    codes = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h0f, 8'h06, 8'h80};
    void'($urandom(32'h8fdf));
    repeat (6) @(negedge core_clk);
    rst_b = 1'b1;
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h00);
    rd(8'h05, 8'hff);
    $display("test reset_values done");
    repeat (4) begin
      v = 8'($urandom);
      wr(8'h01, v);
      rd(8'h01, v);
    end
    wr(8'h01, 8'hff);
    rd(8'h01, 8'hff);
    chk("nv_store pulses", 8'h05, 8'(n_nv));
    $display("test hold_time done");
    foreach (codes[i]) begin
      wr(8'h02, codes[i]);
      e = (codes[i] < 8'h06 || codes[i] == 8'h0f) ? codes[i] : 8'h00;
      chk("serial_rate", e, {4'h0, serial_rate});
      chk("serial_on", {7'h00, e != 8'h00}, {7'h00, serial_on});
      rd(8'h02, codes[i]);
    end
    $display("test serial_rate done");
    repeat (3) begin
      v = 8'($urandom);
      if (v == 8'h01 || v == 8'h02 || v == 8'h05) v = 8'h03;
      wr(v, 8'h5a);
      rd(v, 8'h00);
    end
    $display("test unmapped done");
    wr(8'h05, 8'h20);
    rd(8'h05, 8'h20);
    wr(8'h05, 8'h30);
    rd(8'h05, 8'h30);
    wr(8'h05, 8'hff);
    rd(8'h05, 8'hff);
    for (int s = 0; s < 2; s++) begin
      slow = s[0];
      wr(8'h05, 8'h00);
      repeat (60) @(negedge core_clk);
      chk("restart_req pulses", 8'(s + 1), 8'(n_rr));
      rd(8'h05, 8'hff);
    end
    $display("test keep_alive done");
    cable_ok = 1'b0;
    user_key = 1'b1;
    repeat (40) @(negedge core_clk);
    cable_ok = 1'b1;
    user_key = 1'b0;
    repeat (8) @(negedge core_clk);
    chk("early power actions", 8'h00, 8'(n_bad));
    $display("test cable_loss done");
    final_report();
  end
endmodule : utcr_regs_test
`default_nettype wire
